// ---- wdcfg_top.sv ----
// watchdog configuration registers with window phase and heartbeat timing
// assumes a serial register front end giving one-cycle read/write strobes
// What this block does
// - closed window code 1..63 gives 1.6 ms per step; resets to all ones
// - writing closed window code zero keeps previous open and closed settings
// - open window code 0..3 gives 3.2, 6.4, 9.6, 12.8 ms; resets to 3
// - window error decrement is code plus one; resets to 0111
// - window error increment is code plus one; resets to 0111
// - pass counter decrement is code plus one; resets to 1111
// - pass counter increment is code plus one; resets to 0111
// - total error decrement is code plus one; resets to 0111
// - total error increment is code plus one; resets to 0111
// - heartbeat period in 1.6 ms steps; zero keeps old; resets to 1000111
// - writes to second watchdog config register blocked while lock is 1
// - keep-question bit holds current question after watchdog error; resets 0
// - question period 16 when bit is 0, 256 when 1; resets 0
// - watchdog failure makes reset only when reset enable is 1; resets 0
// - LIN goes receive-only on watchdog error when its bit is 0; resets 1
// - CAN goes receive-only on watchdog error when its bit is 0; resets 1
`timescale 1ns/100ps
`default_nettype none
`include "wdcfg_cfg.svh"

module wdcfg_top #(
  parameter int unsigned TICK_CYCLES =
    (`WDCFG_TICK_NS + `WDCFG_CLK_PERIOD_NS - 1) / `WDCFG_CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // register access
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out,
  output logic rd_valid_out,
  // lock and watchdog events
  input wire logic lock_in,
  input wire logic service_in,
  input wire logic wd_error_in,
  input wire logic wd_fail_in,
  // step sizes
  output logic [4:0] window_error_dec_step_out,
  output logic [4:0] window_error_inc_step_out,
  output logic [4:0] pass_counter_dec_step_out,
  output logic [4:0] pass_counter_inc_step_out,
  output logic [4:0] total_error_dec_step_out,
  output logic [4:0] total_error_inc_step_out,
  // watchdog behaviour
  output logic window_open_out,
  output logic window_error_out,
  output logic heartbeat_out,
  output logic keep_question_out,
  output logic [8:0] question_period_out,
  output logic wd_reset_req_out,
  output logic can_rx_only_out,
  output logic lin_rx_only_out
);

  function automatic logic [4:0] step_of(input logic [3:0] code);
    step_of = {1'b0, code} + 5'h01;
  endfunction

  // registers as written, and the settings actually in use
  wdcfg_pkg::wdcfg_byte_t win_ff, wec_ff, pass_ff, tec_ff, hb_ff, cfg2_ff;
  logic [5:0] eff_closed_ff;
  logic [1:0] eff_open_ff;
  logic [6:0] eff_hb_ff;

  wdcfg_pkg::wdcfg_phase_t phase_ff;
  wdcfg_pkg::wdcfg_phase_t nxt_phase;
  logic [6:0] win_cnt_ff;
  logic [6:0] nxt_win_cnt;
  logic nxt_win_err;
  logic [6:0] hb_cnt_ff;
  logic tick;

  wdcfg_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .tick_out(tick)
  );

  // address decode
  wire hit_win = (addr_in == `WDCFG_ADDR_WIN);
  wire hit_wec = (addr_in == `WDCFG_ADDR_WEC);
  wire hit_pass = (addr_in == `WDCFG_ADDR_PASS);
  wire hit_tec = (addr_in == `WDCFG_ADDR_TEC);
  wire hit_hb = (addr_in == `WDCFG_ADDR_HB);
  wire hit_cfg2 = (addr_in == `WDCFG_ADDR_CFG2);
  wire wr_win = wr_en_in & hit_win;
  wire wr_hb = wr_en_in & hit_hb;
  wire wr_cfg2 = wr_en_in & hit_cfg2 & ~lock_in;
  wire [5:0] wr_closed = wdata_in[`WDCFG_CW_HI:`WDCFG_CW_LO];
  wire [6:0] wr_hb_val = wdata_in[`WDCFG_HB_HI:`WDCFG_HB_LO];
  // zero codes are accepted into the register but never reach the timers
  wire take_win = wr_win & (wr_closed != 6'h00);
  wire take_hb = wr_hb & (wr_hb_val != 7'h00);

  wire [7:0] rd_mux =
    hit_win ? win_ff :
    hit_wec ? wec_ff :
    hit_pass ? pass_ff :
    hit_tec ? tec_ff :
    hit_hb ? (hb_ff & `WDCFG_MASK_HB) :
    hit_cfg2 ? (cfg2_ff & `WDCFG_MASK_CFG2) : 8'h00;

  // register file
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      win_ff <= `WDCFG_RST_WIN;
      wec_ff <= `WDCFG_RST_WEC;
      pass_ff <= `WDCFG_RST_PASS;
      tec_ff <= `WDCFG_RST_TEC;
      hb_ff <= `WDCFG_RST_HB;
      cfg2_ff <= `WDCFG_RST_CFG2;
    end else begin
      if (wr_win) win_ff <= wdata_in;
      if (wr_en_in & hit_wec) wec_ff <= wdata_in;
      if (wr_en_in & hit_pass) pass_ff <= wdata_in;
      if (wr_en_in & hit_tec) tec_ff <= wdata_in;
      if (wr_hb) hb_ff <= wdata_in & `WDCFG_MASK_HB;
      if (wr_cfg2) cfg2_ff <= wdata_in & `WDCFG_MASK_CFG2;
    end
  end

  // settings in use by the timers
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      // shifted reset byte cut to the closed field on purpose
      eff_closed_ff <= 6'(`WDCFG_RST_WIN >> `WDCFG_CW_LO);
      eff_open_ff <= 2'(`WDCFG_RST_WIN);
      eff_hb_ff <= 7'(`WDCFG_RST_HB);
    end else begin
      if (take_win) begin
        eff_closed_ff <= wr_closed;
        eff_open_ff <= wdata_in[`WDCFG_OW_HI:`WDCFG_OW_LO];
      end
      if (take_hb) eff_hb_ff <= wr_hb_val;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_out <= 8'h00;
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= rd_en_in;
      if (rd_en_in) rdata_out <= rd_mux;
    end
  end

  // step sizes: code plus one
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      window_error_dec_step_out <= 5'h00;
      window_error_inc_step_out <= 5'h00;
      pass_counter_dec_step_out <= 5'h00;
      pass_counter_inc_step_out <= 5'h00;
      total_error_dec_step_out <= 5'h00;
      total_error_inc_step_out <= 5'h00;
    end else begin
      window_error_dec_step_out <= step_of(wec_ff[`WDCFG_DEC_HI:`WDCFG_DEC_LO]);
      window_error_inc_step_out <= step_of(wec_ff[`WDCFG_INC_HI:`WDCFG_INC_LO]);
      pass_counter_dec_step_out <= step_of(pass_ff[`WDCFG_DEC_HI:`WDCFG_DEC_LO]);
      pass_counter_inc_step_out <= step_of(pass_ff[`WDCFG_INC_HI:`WDCFG_INC_LO]);
      total_error_dec_step_out <= step_of(tec_ff[`WDCFG_DEC_HI:`WDCFG_DEC_LO]);
      total_error_inc_step_out <= step_of(tec_ff[`WDCFG_INC_HI:`WDCFG_INC_LO]);
    end
  end

  // window phase: closed for code ticks, open for (code+1)*2 ticks
  wire [6:0] closed_ticks = {1'b0, eff_closed_ff};
  wire [6:0] open_ticks = {4'h0, eff_open_ff, 1'b0} + 7'h02;
  wire [6:0] win_cnt_inc = win_cnt_ff + 7'h01;

  always_comb begin
    nxt_phase = phase_ff;
    nxt_win_cnt = win_cnt_ff;
    nxt_win_err = 1'b0;
    case (phase_ff)
      wdcfg_pkg::WDCFG_CLOSED: begin
        if (service_in) begin
          nxt_win_err = 1'b1;
          nxt_win_cnt = 7'h00;
        end else if (tick) begin
          if (win_cnt_inc >= closed_ticks) begin
            nxt_phase = wdcfg_pkg::WDCFG_OPEN;
            nxt_win_cnt = 7'h00;
          end else begin
            nxt_win_cnt = win_cnt_inc;
          end
        end
      end
      wdcfg_pkg::WDCFG_OPEN: begin
        if (service_in) begin
          nxt_phase = wdcfg_pkg::WDCFG_CLOSED;
          nxt_win_cnt = 7'h00;
        end else if (tick) begin
          if (win_cnt_inc >= open_ticks) begin
            nxt_win_err = 1'b1;
            nxt_phase = wdcfg_pkg::WDCFG_CLOSED;
            nxt_win_cnt = 7'h00;
          end else begin
            nxt_win_cnt = win_cnt_inc;
          end
        end
      end
      default: begin
        nxt_phase = wdcfg_pkg::WDCFG_CLOSED;
        nxt_win_cnt = 7'h00;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      phase_ff <= wdcfg_pkg::WDCFG_CLOSED;
      win_cnt_ff <= 7'h00;
      window_error_out <= 1'b0;
      window_open_out <= 1'b0;
    end else begin
      phase_ff <= nxt_phase;
      win_cnt_ff <= nxt_win_cnt;
      window_error_out <= nxt_win_err;
      window_open_out <= (nxt_phase == wdcfg_pkg::WDCFG_OPEN);
    end
  end

  // heartbeat: a period change takes effect at once, compared against the running count on the next tick
  wire [6:0] hb_cnt_inc = hb_cnt_ff + 7'h01;
  wire hb_wrap = tick & (hb_cnt_inc >= eff_hb_ff);

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hb_cnt_ff <= 7'h00;
      heartbeat_out <= 1'b0;
    end else begin
      heartbeat_out <= hb_wrap;
      if (hb_wrap) hb_cnt_ff <= 7'h00;
      else if (tick) hb_cnt_ff <= hb_cnt_inc;
    end
  end

  // decoded control to the watchdog core and transceivers
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      keep_question_out <= 1'b0;
      question_period_out <= `WDCFG_QP_SHORT;
      wd_reset_req_out <= 1'b0;
      can_rx_only_out <= 1'b0;
      lin_rx_only_out <= 1'b0;
    end else begin
      keep_question_out <= wd_error_in & cfg2_ff[`WDCFG_KQ_BIT];
      question_period_out <= cfg2_ff[`WDCFG_QG_BIT] ? `WDCFG_QP_LONG : `WDCFG_QP_SHORT;
      wd_reset_req_out <= wd_fail_in & cfg2_ff[`WDCFG_REN_BIT];
      lin_rx_only_out <= wd_error_in & ~cfg2_ff[`WDCFG_LIN_ERROR_MODE_SELECT_BIT];
      can_rx_only_out <= wd_error_in & ~cfg2_ff[`WDCFG_CAN_ERROR_MODE_SELECT_BIT];
    end
  end

  // checks
  sequence s_locked_write;
    wr_en_in && hit_cfg2 && lock_in;
  endsequence

  property p_lock;
    @(posedge clk_in) disable iff (!rstn_in)
    s_locked_write |=> $stable(cfg2_ff);
  endproperty
  a_lock: assert property (p_lock) else $error("locked register changed");

  property p_closed_zero;
    @(posedge clk_in) disable iff (!rstn_in)
    (wr_win && wr_closed == 6'h00) |=> ($stable(eff_closed_ff) && $stable(eff_open_ff));
  endproperty
  a_closed_zero: assert property (p_closed_zero) else $error("zero closed code changed window");

  property p_closed_take;
    @(posedge clk_in) disable iff (!rstn_in)
    take_win |=> (eff_closed_ff == $past(wr_closed)) &&
      (eff_open_ff == $past(wdata_in[`WDCFG_OW_HI:`WDCFG_OW_LO]));
  endproperty
  a_closed_take: assert property (p_closed_take) else $error("window setting not taken");

  property p_hb_zero;
    @(posedge clk_in) disable iff (!rstn_in)
    (wr_hb && wr_hb_val == 7'h00) |=> $stable(eff_hb_ff);
  endproperty
  a_hb_zero: assert property (p_hb_zero) else $error("zero heartbeat changed period");

  property p_qperiod;
    @(posedge clk_in) disable iff (!rstn_in)
    wr_cfg2 |=> ##1
      (question_period_out == ($past(wdata_in[`WDCFG_QG_BIT], 2) ? `WDCFG_QP_LONG : `WDCFG_QP_SHORT));
  endproperty
  a_qperiod: assert property (p_qperiod) else $error("question period wrong");

  property p_reset_gate;
    @(posedge clk_in) disable iff (!rstn_in)
    wd_reset_req_out |-> $past(wd_fail_in) && $past(cfg2_ff[`WDCFG_REN_BIT]);
  endproperty
  a_reset_gate: assert property (p_reset_gate) else $error("reset request without enable");

  property p_can;
    @(posedge clk_in) disable iff (!rstn_in)
    (wd_error_in && !cfg2_ff[`WDCFG_CAN_ERROR_MODE_SELECT_BIT]) |=> can_rx_only_out;
  endproperty
  a_can: assert property (p_can) else $error("can not receive only");

  property p_lin;
    @(posedge clk_in) disable iff (!rstn_in)
    (wd_error_in && cfg2_ff[`WDCFG_LIN_ERROR_MODE_SELECT_BIT]) |=> !lin_rx_only_out;
  endproperty
  a_lin: assert property (p_lin) else $error("lin forced receive only");

  property p_keep;
    @(posedge clk_in) disable iff (!rstn_in)
    keep_question_out |-> $past(cfg2_ff[`WDCFG_KQ_BIT]) && $past(wd_error_in);
  endproperty
  a_keep: assert property (p_keep) else $error("keep question without setup");

  property p_step;
    @(posedge clk_in) disable iff (!rstn_in)
    (wr_en_in && hit_wec) |=> ##1
      (window_error_inc_step_out == {1'b0, $past(wdata_in[`WDCFG_INC_HI:`WDCFG_INC_LO], 2)} + 5'h01);
  endproperty
  a_step: assert property (p_step) else $error("increment step wrong");

  property p_early_service;
    @(posedge clk_in) disable iff (!rstn_in)
    (service_in && phase_ff == wdcfg_pkg::WDCFG_CLOSED) |=> window_error_out && !window_open_out;
  endproperty
  a_early_service: assert property (p_early_service) else $error("early service not flagged");

  property p_open_service;
    @(posedge clk_in) disable iff (!rstn_in)
    (service_in && phase_ff == wdcfg_pkg::WDCFG_OPEN) |=> !window_error_out && !window_open_out;
  endproperty
  a_open_service: assert property (p_open_service) else $error("open service not accepted");
endmodule

`default_nettype wire

// ---- wdcfg_cfg.svh ----
// constants of the watchdog configuration block: offsets, fields, resets, timing
// assumes inclusion by bare name from the top module and the testbench
`ifndef WDCFG_CFG_SVH
`define WDCFG_CFG_SVH

// timing
`define WDCFG_CLK_PERIOD_NS 20
`define WDCFG_TICK_NS 1600000

// register offsets on the serial register interface
`define WDCFG_ADDR_WIN 8'h5e
`define WDCFG_ADDR_WEC 8'h5f
`define WDCFG_ADDR_PASS 8'h60
`define WDCFG_ADDR_TEC 8'h61
`define WDCFG_ADDR_HB 8'h62
`define WDCFG_ADDR_CFG2 8'h64

// reset values
`define WDCFG_RST_WIN 8'hff
`define WDCFG_RST_WEC 8'h77
`define WDCFG_RST_PASS 8'hf7
`define WDCFG_RST_TEC 8'h77
`define WDCFG_RST_HB 8'h47
`define WDCFG_RST_CFG2 8'h03

// implemented bits
`define WDCFG_MASK_HB 8'h7f
`define WDCFG_MASK_CFG2 8'h1f

// field positions
`define WDCFG_CW_HI 7
`define WDCFG_CW_LO 2
`define WDCFG_OW_HI 1
`define WDCFG_OW_LO 0
`define WDCFG_DEC_HI 7
`define WDCFG_DEC_LO 4
`define WDCFG_INC_HI 3
`define WDCFG_INC_LO 0
`define WDCFG_HB_HI 6
`define WDCFG_HB_LO 0
`define WDCFG_KQ_BIT 4
`define WDCFG_QG_BIT 3
`define WDCFG_REN_BIT 2
`define WDCFG_LIN_ERROR_MODE_SELECT_BIT 1
`define WDCFG_CAN_ERROR_MODE_SELECT_BIT 0

// question periods
`define WDCFG_QP_SHORT 9'h010
`define WDCFG_QP_LONG 9'h100

`endif

// ---- wdcfg_pkg.sv ----
// types of the watchdog configuration block
// assumes wdcfg_cfg.svh holds all numeric constants
package wdcfg_pkg;
  typedef logic [7:0] wdcfg_byte_t;

  typedef enum logic [1:0] {
    WDCFG_CLOSED = 2'b00,
    WDCFG_OPEN = 2'b01
  } wdcfg_phase_t;
endpackage

// ---- wdcfg_tick.sv ----
// base tick divider: one-cycle enable every TICK_CYCLES clocks (1.6 ms step)
// assumes a single clock domain and asynchronous active-low reset
`timescale 1ns/100ps
`default_nettype none

module wdcfg_tick #(
  parameter int unsigned TICK_CYCLES = 80000
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // enable pulse
  output logic tick_out
);
  localparam int unsigned CW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  wire wrap = (cnt_ff == LAST);

  assign nxt_cnt = wrap ? '0 : cnt_ff + CW'(1);

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_ff <= '0;
      tick_out <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_out <= wrap;
    end
  end
endmodule

`default_nettype wire

// ---- wdcfg_host.sv ----
// host model: services the window watchdog three cycles into a phase and again every 256 cycles while it lasts, in the open window or early
// assumes the device window phase output and the device clock
`timescale 1ns/100ps
`default_nettype none

module wdcfg_host (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // control and device phase
  input wire logic enable_in,
  input wire logic early_in,
  input wire logic window_open_in,
  // service strobe
  output logic service_out
);
  logic [7:0] age_ff;
  logic last_ff;
  wire logic in_phase;

  assign in_phase = early_in ? !window_open_in : window_open_in;

  // strobe three cycles into the phase so an open service never lands on the closing edge
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      age_ff <= 8'h00;
      last_ff <= 1'b0;
      service_out <= 1'b0;
    end else begin
      last_ff <= window_open_in;
      age_ff <= (last_ff != window_open_in) ? 8'h00 : age_ff + 8'h01;
      service_out <= enable_in && in_phase && (age_ff == 8'h01);
    end
  end
endmodule
`default_nettype wire

// ---- wdcfg_top_bench.sv ----
// testbench of the watchdog configuration block: register calls, timing and host service
// assumes wdcfg_top, wdcfg_host and the constants header; short tick for run length
`timescale 1ns/100ps
`default_nettype none
`include "wdcfg_cfg.svh"

module wdcfg_top_bench;
  localparam int T = 4;
  logic clk_in, rstn_in, wr_en, rd_en, lock, wd_error, wd_fail, host_en, host_early;
  logic [7:0] addr, wdata;
  wire logic service;
  wire logic [7:0] rdata;
  wire logic rd_valid, win_open, win_err, hb, keep, reset_req, can_ro, lin_ro;
  wire logic [4:0] wdec, winc, pdec, pinc, tdec, tinc;
  wire logic [8:0] qp;
  int n_mismatch = 0;
  int tests_run = 0;

  wdcfg_top #(.TICK_CYCLES(T)) dut (.clk_in(clk_in), .rstn_in(rstn_in), .wr_en_in(wr_en),
    .rd_en_in(rd_en), .addr_in(addr), .wdata_in(wdata), .rdata_out(rdata), .rd_valid_out(rd_valid),
    .lock_in(lock), .service_in(service), .wd_error_in(wd_error), .wd_fail_in(wd_fail),
    .window_error_dec_step_out(wdec), .window_error_inc_step_out(winc),
    .pass_counter_dec_step_out(pdec), .pass_counter_inc_step_out(pinc),
    .total_error_dec_step_out(tdec), .total_error_inc_step_out(tinc),
    .window_open_out(win_open), .window_error_out(win_err), .heartbeat_out(hb),
    .keep_question_out(keep), .question_period_out(qp), .wd_reset_req_out(reset_req),
    .can_rx_only_out(can_ro), .lin_rx_only_out(lin_ro));

  wdcfg_host host (.clk_in(clk_in), .rstn_in(rstn_in), .enable_in(host_en), .early_in(host_early),
    .window_open_in(win_open), .service_out(service));

  always #10 clk_in = ~clk_in;

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic step();
    @(posedge clk_in);
    #1;
  endtask

  task automatic give_up();
    n_mismatch++;
    $display("mismatch wait expected event seen none");
    complete_run();
  endtask

  // every call ends one cycle after the strobe is dropped, so strobes never touch
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wr_en = 1'b1;
    addr = a;
    wdata = d;
    step();
    wr_en = 1'b0;
    step();
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    rd_en = 1'b1;
    addr = a;
    step();
    rd_en = 1'b0;
    check("read valid", 16'h0001, {15'h0000, rd_valid});
    check("read data", {8'h00, exp}, {8'h00, rdata});
    step();
  endtask

  task automatic wait_lvl(input logic v);
    int n;
    n = 0;
    while (win_open !== v) begin
      if (++n > 3000) give_up();
      step();
    end
  endtask

  // skip a whole period after a change, then time one open and one closed phase
  task automatic measure(input int exp_open, input int exp_closed);
    int hi, lo, er;
    hi = 0;
    lo = 0;
    er = 0;
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    while (win_open === 1'b1 && hi < 3000) begin
      er += int'(win_err === 1'b1);
      hi++;
      step();
    end
    while (win_open === 1'b0 && lo < 3000) begin
      er += int'(win_err === 1'b1);
      lo++;
      step();
    end
    check("open cycles", 16'(exp_open), 16'(hi));
    check("closed cycles", 16'(exp_closed), 16'(lo));
    check("expiry errors", 16'h0001, 16'(er));
  endtask

  task automatic count_err(input int cycles, output int er);
    er = 0;
    repeat (cycles) begin
      er += int'(win_err === 1'b1);
      step();
    end
  endtask

  task automatic hb_period(input int exp);
    int n;
    n = 0;
    repeat (2) begin
      while (hb !== 1'b1 && n < 3000) begin
        n++;
        step();
      end
      step();
    end
    n = 1;
    while (hb !== 1'b1 && n < 3000) begin
      n++;
      step();
    end
    check("heartbeat cycles", 16'(exp), 16'(n));
  endtask

  initial begin
    int er;
    clk_in = 1'b0;
    rstn_in = 1'b0;
    {wr_en, rd_en, lock, wd_error, wd_fail, host_en, host_early} = 7'h00;
    addr = 8'h00;
    wdata = 8'h00;
    repeat (4) @(posedge clk_in);
    #1;
    rstn_in = 1'b1;
    step();
    rd(`WDCFG_ADDR_WIN, 8'hff);
    rd(`WDCFG_ADDR_WEC, 8'h77);
    rd(`WDCFG_ADDR_PASS, 8'hf7);
    rd(`WDCFG_ADDR_TEC, 8'h77);
    rd(`WDCFG_ADDR_HB, 8'h47);
    rd(`WDCFG_ADDR_CFG2, 8'h03);
    rd(8'h63, 8'h00);
    check("reset steps", {1'b0, 5'h08, 5'h08, 5'h10}, {1'b0, wdec, winc, pdec});
    check("reset steps", {1'b0, 5'h08, 5'h08, 5'h08}, {1'b0, pinc, tdec, tinc});
    check("reset period", 16'h0010, {7'h00, qp});
    hb_period(71 * T);
    measure(8 * T, 63 * T);
    $display("test reset values done");
    wr(`WDCFG_ADDR_WEC, 8'h0f);
    wr(`WDCFG_ADDR_PASS, 8'hf0);
    wr(`WDCFG_ADDR_TEC, 8'h3c);
    step();
    check("written steps", {1'b0, 5'h01, 5'h10, 5'h10}, {1'b0, wdec, winc, pdec});
    check("written steps", {1'b0, 5'h01, 5'h04, 5'h0d}, {1'b0, pinc, tdec, tinc});
    $display("test step sizes done");
    wr(`WDCFG_ADDR_CFG2, 8'hff);
    rd(`WDCFG_ADDR_CFG2, 8'h1f);
    wd_error = 1'b1;
    wd_fail = 1'b1;
    step();
    step();
    check("keep lin can reset", 16'h0009, {12'h000, keep, lin_ro, can_ro, reset_req});
    check("long period", 16'h0100, {7'h00, qp});
    lock = 1'b1;
    wr(`WDCFG_ADDR_CFG2, 8'h00);
    rd(`WDCFG_ADDR_CFG2, 8'h1f);
    lock = 1'b0;
    wr(`WDCFG_ADDR_CFG2, 8'h00);
    step();
    check("keep lin can reset", 16'h0006, {12'h000, keep, lin_ro, can_ro, reset_req});
    check("short period", 16'h0010, {7'h00, qp});
    wr(`WDCFG_ADDR_CFG2, 8'h11);
    step();
    check("keep lin can reset", 16'h000c, {12'h000, keep, lin_ro, can_ro, reset_req});
    wd_error = 1'b0;
    wd_fail = 1'b0;
    $display("test second config done");
    for (int o = 0; o < 4; o++) begin
      wr(`WDCFG_ADDR_WIN, {6'h02, 2'(o)});
      measure((o + 1) * 2 * T, 2 * T);
    end
    wr(`WDCFG_ADDR_WIN, 8'h00);
    measure(8 * T, 2 * T);
    rd(`WDCFG_ADDR_WIN, 8'h00);
    wr(`WDCFG_ADDR_WIN, 8'h04);
    measure(2 * T, T);
    $display("test window timing done");
    host_en = 1'b1;
    count_err(300, er);
    check("serviced errors", 16'h0000, 16'(er));
    host_early = 1'b1;
    count_err(300, er);
    check("early errors seen", 16'h0001, 16'(er != 0));
    host_en = 1'b0;
    $display("test host service done");
    wr(`WDCFG_ADDR_HB, 8'h02);
    hb_period(2 * T);
    wr(`WDCFG_ADDR_HB, 8'h00);
    hb_period(2 * T);
    $display("test heartbeat done");
    complete_run();
  end
endmodule
`default_nettype wire
